// ---- dsi_pkg.sv ----
// Purpose: shared constants for the sample input interface
// Assumes: 14-bit sample words, one core clock
// Notes:   coding modes and fifo sizing live here
package dsi_pkg;
    localparam int unsigned SAMPLE_W      = 14;             // sample word width
    localparam int unsigned MSB_POS       = 13;             // most significant bit position
    localparam int unsigned FIFO_DEPTH    = 32;             // buffer depth in words
    localparam int unsigned FULL_CODE     = 16383;          // all-ones code
    localparam int unsigned CODE_SPAN     = 16384;          // full-scale divisor
    localparam logic [13:0] SAMPLE_RESET  = 14'h0000;       // word held after reset
    localparam logic        CODING_BINARY = 1'b0;           // select tied low
    localparam logic        CODING_TWOS   = 1'b1;           // select tied high
    localparam int unsigned MAX_RATE_MSPS = 125;            // source rate limit
    localparam int unsigned LOW_RATE_MSPS = 70;             // limit at low supply
    // coding format of the incoming word
    typedef enum logic {DSI_BINARY, DSI_TWOS} dsi_coding_e;
endpackage

// ---- dsi_sync2.sv ----
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: input is asynchronous to clk
// Notes:   first stage read only by second stage
module dsi_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;    // first stage
    logic [W-1:0] meta_d;    // first stage next
    logic [W-1:0] sync_q;    // second stage
    logic [W-1:0] sync_d;    // second stage next

    // next values, hold while disabled
    always_comb
    begin
        meta_d = en ? din : meta_q;
        sync_d = en ? meta_q : sync_q;
    end

    // register both stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;
endmodule

// ---- dsi_fifo.sv ----
// Purpose: sample buffer with valid/ready on both sides
// Assumes: single clock, flip-flop storage
// Notes:   full and empty are exact; no write when full
module dsi_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // storage
    logic [AW-1:0]    wr_q, wr_d;      // write index
    logic [AW-1:0]    rd_q, rd_d;      // read index
    logic [AW:0]      cnt_q, cnt_d;    // fill level
    logic             push, pop;       // handshakes

    assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // pointer and level next values
    always_comb
    begin
        push  = en && in_valid && in_ready;
        pop   = en && out_valid && out_ready;
        wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1)) : wr_q;
        rd_d  = pop  ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1)) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // register pointers and storage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            if (push)
            begin
                mem_q[wr_q] <= in_data;
            end
        end
    end
endmodule

// ---- dsi_top.sv ----
// Purpose: digital input side of a 14-bit current-steering converter
// Assumes: sample clock is clk; source obeys its rate limits
// Notes:   captured word is buffered or bypassed, decoded, then drives steering codes
module dsi_top #(
    parameter int unsigned DEPTH = dsi_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic [13:0] sample_word_lines,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    input  wire logic        coding_select,
    input  wire logic        power_down,
    input  wire logic        drain_ready,
    output logic      [13:0] positive_current_output,
    output logic      [13:0] complementary_current_output,
    output logic             outputs_enabled,
    output logic             standby
);
    localparam int unsigned W = dsi_pkg::SAMPLE_W;

    logic       rst_m_q, rst_s_q;        // reset release pair
    logic       rst_n;                   // internal reset
    logic [W+1:0] pin_sync;              // synchronised pins
    logic [W-1:0] word_s;                // synchronised word
    logic       valid_s;                 // synchronised valid
    logic       sel_s;                   // synchronised coding select
    logic       pd_s;                    // synchronised power-down
    logic [W-1:0] cap_q, cap_d;          // captured word
    logic       cap_v_q, cap_v_d;        // captured word present
    logic       cap_mode_q, cap_mode_d;  // coding latched with word
    logic       fifo_in_ready;           // buffer accepts
    logic       fifo_out_valid;          // buffer holds word
    logic [W:0] fifo_out_data;           // word plus coding
    logic [W:0] head_data;               // oldest word plus coding
    logic       head_v;                  // a word is ready to drain
    logic       bypass;                  // capture goes straight out
    logic       fifo_in_valid;           // capture pushed into buffer
    logic [W-1:0] code;                  // decoded binary code
    logic [W-1:0] pos_q, pos_d;          // positive steering code
    logic [W-1:0] cmp_q, cmp_d;          // complementary steering code
    logic       en_q, en_d;              // outputs on
    logic       sb_q, sb_d;              // standby flag
    logic       rdy_q, rdy_d;            // ready toward source

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end
    assign rst_n = rst_s_q;

    // pins come from outside, two flops each
    dsi_sync2 #(
        .W (W + 2)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (clk_en),
        .din   ({power_down, coding_select, sample_word_lines}),
        .dout  (pin_sync)
    );
    assign word_s = pin_sync[W-1:0];
    assign sel_s  = pin_sync[W];
    assign pd_s   = pin_sync[W+1];

    // valid is a pin too, its own pair keeps word and valid aligned
    dsi_sync2 #(
        .W (1)
    ) u_sync_v (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (clk_en),
        .din   (sample_valid),
        .dout  (valid_s)
    );

    // capture stage next values
    always_comb
    begin
        cap_d      = cap_q;
        cap_v_d    = cap_v_q;
        cap_mode_d = cap_mode_q;
        if (clk_en)
        begin
            if (cap_v_q && !fifo_in_ready)
            begin
                cap_v_d = 1'b1;                       // buffer full, word waits
            end
            else if (valid_s && fifo_in_ready)
            begin
                cap_d      = word_s;
                cap_mode_d = sel_s;
                cap_v_d    = 1'b1;
            end
            else
            begin
                cap_v_d = 1'b0;
            end
        end
    end

    // capture registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_q      <= dsi_pkg::SAMPLE_RESET;
            cap_v_q    <= 1'b0;
            cap_mode_q <= dsi_pkg::CODING_BINARY;
        end
        else
        begin
            cap_q      <= cap_d;
            cap_v_q    <= cap_v_d;
            cap_mode_q <= cap_mode_d;
        end
    end

    // buffer between capture and converter core
    dsi_fifo #(
        .WIDTH (W + 1),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .en        (clk_en),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({cap_mode_q, cap_q}),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out_data)
    );

    // oldest word: buffer head first, else the capture register
    assign head_v    = fifo_out_valid || cap_v_q;
    assign head_data = fifo_out_valid ? fifo_out_data : {cap_mode_q, cap_q};

    // empty buffer and willing core: skip the buffer, keeps one cycle latency
    assign bypass        = cap_v_q && !fifo_out_valid && drain_ready;
    assign fifo_in_valid = cap_v_q && !bypass;

    // decode coding mode into plain binary
    always_comb
    begin
        code = head_data[W-1:0];
        if (head_data[W] == dsi_pkg::CODING_TWOS)
        begin
            code[dsi_pkg::MSB_POS] = ~code[dsi_pkg::MSB_POS];
        end
    end

    // output stage next values
    always_comb
    begin
        pos_d = pos_q;
        cmp_d = cmp_q;
        en_d  = en_q;
        sb_d  = sb_q;
        rdy_d = rdy_q;
        if (clk_en)
        begin
            sb_d  = pd_s;
            en_d  = ~pd_s;
            rdy_d = fifo_in_ready;
            if (pd_s)
            begin
                pos_d = '0;                           // currents off
                cmp_d = '0;
            end
            else if (head_v && drain_ready)
            begin
                pos_d = code;
                cmp_d = W'(dsi_pkg::FULL_CODE) - code;
            end
        end
    end

    // output registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_q <= '0;
            cmp_q <= '0;
            en_q  <= 1'b0;
            sb_q  <= 1'b0;
            rdy_q <= 1'b0;
        end
        else
        begin
            pos_q <= pos_d;
            cmp_q <= cmp_d;
            en_q  <= en_d;
            sb_q  <= sb_d;
            rdy_q <= rdy_d;
        end
    end

    assign positive_current_output      = pos_q;
    assign complementary_current_output = cmp_q;
    assign outputs_enabled              = en_q;
    assign standby                      = sb_q;
    assign sample_ready                 = rdy_q;

    // while enabled, complement pairs with positive or both are zero
    property p_complement_sum;
        @(posedge clk) disable iff (!rst_n)
        en_q |-> (32'(pos_q) + 32'(cmp_q) == dsi_pkg::FULL_CODE) || (pos_q == '0 && cmp_q == '0);
    endproperty
    a_complement_sum: assert property (p_complement_sum) else $error("outputs not complementary");

    // drained word appears one cycle later
    property p_latency;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !pd_s && head_v && drain_ready) |=> (pos_q == $past(code));
    endproperty
    a_latency: assert property (p_latency) else $error("latency not one cycle");

    // twos mode flips the top bit only
    property p_twos;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !pd_s && head_v && drain_ready && head_data[W] == dsi_pkg::CODING_TWOS)
            |=> (pos_q == ($past(head_data[W-1:0]) ^ 14'h2000));
    endproperty
    a_twos: assert property (p_twos) else $error("twos decode wrong");

    // binary mode passes word unchanged
    property p_binary;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !pd_s && head_v && drain_ready && head_data[W] == dsi_pkg::CODING_BINARY)
            |=> (pos_q == $past(head_data[W-1:0]));
    endproperty
    a_binary: assert property (p_binary) else $error("binary decode wrong");

    // power-down kills currents next cycle
    property p_power_down;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && pd_s) |=> (pos_q == '0 && cmp_q == '0 && standby && !outputs_enabled);
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down ignored");

    // all ones gives full positive
    property p_full_ones;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !pd_s && head_v && drain_ready && code == 14'h3FFF)
            |=> (cmp_q == '0);
    endproperty
    a_full_ones: assert property (p_full_ones) else $error("full scale wrong");

    // all zeros gives full complement
    property p_full_zeros;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !pd_s && head_v && drain_ready && code == 14'h0000)
            |=> (cmp_q == 14'h3FFF);
    endproperty
    a_full_zeros: assert property (p_full_zeros) else $error("zero scale wrong");

    // capture takes the whole word with its coding
    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && valid_s && fifo_in_ready)
            |=> (cap_v_q && cap_q == $past(word_s) && cap_mode_q == $past(sel_s));
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    // a captured word waits while the buffer is full
    property p_hold_pending;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && cap_v_q && !fifo_in_ready) |=> (cap_v_q && $stable(cap_q));
    endproperty
    a_hold_pending: assert property (p_hold_pending) else $error("pending word lost");

    // bypassed word goes out next edge and never enters the buffer
    property p_bypass;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !pd_s && bypass) |=> (!fifo_out_valid && pos_q == $past(code));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass latency wrong");

    // ready toward the source is the buffer space one cycle late
    property p_ready_view;
        @(posedge clk) disable iff (!rst_n)
        clk_en |=> (sample_ready == $past(fifo_in_ready));
    endproperty
    a_ready_view: assert property (p_ready_view) else $error("ready view wrong");
endmodule

// ---- dsi_src_model.sv ----
// Purpose: model of the logic that feeds sample words
// Assumes: driven at the falling edge of clk
// Notes:   lines show the inverse word between samples
module dsi_src_model #(
    parameter int unsigned GAP = 2
) (
    input  wire logic        clk,
    output logic      [13:0] word,
    output logic             valid,
    output logic             mode
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle state at time zero
    initial
    begin
        word  = 14'h0000;
        valid = 1'b0;
        mode  = 1'b0;
    end

    // one word, all fourteen lines, then GAP-1 idle cycles
    task automatic put(input logic [13:0] w, input logic m);
        @(negedge clk);
        word  <= w;
        valid <= 1'b1;
        mode  <= m;
        // spacing keeps the rate at 100 MSPS or less
        repeat (GAP - 1)
        begin
            @(negedge clk);
            valid <= 1'b0;
            word  <= ~w;
        end
    endtask
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the sample input block
// Assumes: 200 MHz clock, inputs driven at the falling edge
// Notes:   a monitor pairs each output change with the oldest note
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;          // core clock
    logic        resetn = 1'b0;       // active low reset
    logic        clk_en = 1'b1;       // clock enable
    logic        power_down = 1'b0;   // low except during the power-down test
    logic        drain_ready = 1'b1;  // core takes words
    logic [13:0] word;                // sample lines
    logic        valid;               // word present
    logic        mode;                // coding select
    logic        sample_ready;
    logic [13:0] pos;
    logic [13:0] comp;
    logic        outputs_enabled;
    logic        standby;
    logic [13:0] exp_q[$];            // expected steering codes
    logic [13:0] last_pos = 14'h0000; // last seen output
    logic [13:0] prev_exp = 14'h0000; // last noted code
    logic [13:0] w;                   // scratch word
    logic        m;                   // scratch mode
    logic        mon_on = 1'b1;       // monitor active
    int          fails = 0;
    int          total_checks = 0;

    always #2.5 clk = ~clk;

    dsi_src_model dsi_src_model_i (
        .clk   (clk),
        .word  (word),
        .valid (valid),
        .mode  (mode)
    );

    dsi_top dsi_top_i (
        .clk                          (clk),
        .resetn                       (resetn),
        .clk_en                       (clk_en),
        .sample_word_lines            (word),
        .sample_valid                 (valid),
        .sample_ready                 (sample_ready),
        .coding_select                (mode),
        .power_down                   (power_down),
        .drain_ready                  (drain_ready),
        .positive_current_output      (pos),
        .complementary_current_output (comp),
        .outputs_enabled              (outputs_enabled),
        .standby                      (standby)
    );

    // compare and count
    task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic results;
        if (fails == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // note the expected code, then hand the word to the source
    task automatic send(input logic [13:0] wd, input logic md);
        logic [13:0] p;
        p = wd ^ {md, 13'h0000};  // top bit flipped in twos mode
        exp_q.push_back(p);
        prev_exp = p;
        dsi_src_model_i.put(wd, md);
    endtask

    // random word whose code differs from the previous one
    task automatic pick;
        do
        begin
            w = 14'($urandom);
            m = 1'($urandom);
        end
        while ((w ^ {m, 13'h0000}) == prev_exp);
    endtask

    // bounded wait until every note is matched
    task automatic wait_empty;
        for (int i = 0; i < 400 && exp_q.size() != 0; i++)
            @(negedge clk);
        check("pending", 14'(exp_q.size()), 14'h0000);
    endtask

    // monitor: every output change consumes one note
    always @(posedge clk)
    begin
        #1;
        if (mon_on && pos !== last_pos)
        begin
            last_pos = pos;
            w = (exp_q.size() != 0) ? exp_q.pop_front() : ~pos;
            check("positive", pos, w);
            check("complement", comp, 14'h3FFF - w);
            check("enabled", 14'(outputs_enabled), 14'h0001);
        end
    end

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hAA5B));
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        // boundary words in both codings
        send(14'h3FFF, 1'b0);
        send(14'h0000, 1'b0);
        send(14'h3FFF, 1'b1);
        send(14'h0000, 1'b1);
        // random words with coding picked at random per word
        repeat (40)
        begin
            pick();
            send(w, m);
        end
        wait_empty();
        // fill the buffer with the core stalled
        drain_ready = 1'b0;
        repeat (32)
        begin
            pick();
            send(w, m);
        end
        repeat (8) @(negedge clk);
        check("ready_full", 14'(sample_ready), 14'h0000);
        // drain with random stalls
        for (int i = 0; i < 400 && exp_q.size() != 0; i++)
        begin
            @(negedge clk);
            drain_ready = 1'($urandom);
        end
        drain_ready = 1'b1;
        wait_empty();
        check("ready_free", 14'(sample_ready), 14'h0001);
        // a word offered while frozen must not appear
        clk_en = 1'b0;
        pick();
        dsi_src_model_i.put(w, m);
        repeat (4) @(negedge clk);
        clk_en = 1'b1;
        pick();
        send(w, m);
        wait_empty();
        // power down zeroes both outputs
        mon_on = 1'b0;
        power_down = 1'b1;
        repeat (6) @(negedge clk);
        check("standby", 14'(standby), 14'h0001);
        check("pd_enabled", 14'(outputs_enabled), 14'h0000);
        check("pd_positive", pos, 14'h0000);
        check("pd_complement", comp, 14'h0000);
        power_down = 1'b0;
        repeat (6) @(negedge clk);
        check("awake", 14'(standby), 14'h0000);
        last_pos = pos;
        prev_exp = pos;
        mon_on = 1'b1;
        pick();
        send(w, m);
        wait_empty();
        results();
    end
endmodule
